// [include/ssr_pkg.sv]
// ssr_pkg: constants, pin carrier and state encoding for the serial sram slave
// assumes a single system clock that oversamples the serial link pins

package ssr_pkg;

   // ----------------------------------------------------------------------
   // byte format
   // ----------------------------------------------------------------------
   localparam int unsigned SSR_BYTE_W   = 8;
   localparam int unsigned SSR_ADDR_W   = 7;
   localparam int unsigned SSR_IDX_W    = 8;
   localparam int unsigned SSR_DIR_BIT  = 7;
   localparam logic        SSR_DIR_READ = 1'b0;
   localparam logic [2:0]  SSR_BIT_LAST = 3'h7;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [2:0]  SSR_CNT_RST  = 3'h0;
   localparam logic [6:0]  SSR_ADDR_RST = 7'h00;
   localparam logic [7:0]  SSR_BYTE_RST = 8'h00;
   localparam logic        SSR_SDO_IDLE = 1'b1;
   localparam logic        SSR_SCK_IDLE = 1'b1;

   // pins from the master, all asynchronous to the system clock
   typedef struct packed {
      logic ce;
      logic ss_n;
      logic sck;
      logic sdi;
      logic bank_select;
   } ssr_pins_t;

   localparam ssr_pins_t SSR_PINS_RST = '{ce: 1'b0, ss_n: 1'b1, sck: 1'b1,
                                          sdi: 1'b0, bank_select: 1'b0};

   // interface phase
   typedef enum logic [1:0] {
      SSR_ST_ADDR  = 2'b00,
      SSR_ST_READ  = 2'b01,
      SSR_ST_WRITE = 2'b10
   } ssr_state_t;

endpackage

// [verilog/ssr_serial_sram.sv]
// ssr_serial_sram: serial slave interface and byte storage of a small static ram
// assumes the link pins change slowly against i_clk_sys (serial clock period 800 ns)

module ssr_serial_sram #(
   parameter bit P_TWO_BANKS = 1'b1
) (
   // system
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   // serial link pins
   input  wire ssr_pkg::ssr_pins_t i_pins,
   // serial data out
   output logic                   o_sdo,
   output logic                   o_sdo_oe
);
   import ssr_pkg::*;

   localparam int unsigned WORDS = P_TWO_BANKS ? 256 : 128;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // memory index from bank and word address; single bank forces the half to 0
   function automatic logic [SSR_IDX_W-1:0] mem_idx(input logic bank,
                                                    input logic [SSR_ADDR_W-1:0] addr);
      mem_idx = {bank & P_TWO_BANKS, addr};
   endfunction

   // next word address, wrapping inside the half
   function automatic logic [SSR_ADDR_W-1:0] addr_next(input logic [SSR_ADDR_W-1:0] addr);
      addr_next = addr + 7'h01;
   endfunction

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   ssr_pins_t sync1_q;
   ssr_pins_t sync2_q;
   logic      sck_last_q;

   // two stages per pin, plus one more on the clock for edge finding
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_q    <= SSR_PINS_RST;
         sync2_q    <= SSR_PINS_RST;
         sck_last_q <= SSR_SCK_IDLE;
      end else begin
         sync1_q    <= i_pins;
         sync2_q    <= sync1_q;
         sck_last_q <= sync2_q.sck;
      end
   end

   logic en;
   logic sck_rise;
   logic sck_fall;

   // enable and gated serial clock edges
   assign en       = sync2_q.ce & ~sync2_q.ss_n;
   assign sck_rise = en & sync2_q.sck & ~sck_last_q;
   assign sck_fall = en & ~sync2_q.sck & sck_last_q;

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   logic [SSR_BYTE_W-1:0] mem [0:WORDS-1];

   // ----------------------------------------------------------------------
   // serial engine
   // ----------------------------------------------------------------------
   ssr_state_t            state_q,  state_d;
   logic [2:0]            cnt_q,    cnt_d;
   logic [SSR_BYTE_W-1:0] rx_q,     rx_d;
   logic [SSR_BYTE_W-1:0] tx_q,     tx_d;
   logic [SSR_ADDR_W-1:0] addr_q,   addr_d;
   logic                  sdo_q,    sdo_d;
   logic                  oe_q,     oe_d;
   logic                  wr_en;
   logic [SSR_IDX_W-1:0]  wr_idx;
   logic [SSR_BYTE_W-1:0] cap_byte;
   logic                  byte_done;

   // byte being completed by this rising edge, msb arrived first
   assign cap_byte  = {rx_q[SSR_BYTE_W-2:0], sync2_q.sdi};
   assign byte_done = sck_rise && (cnt_q == SSR_BIT_LAST);

   // next values of the serial engine
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      rx_d    = rx_q;
      tx_d    = tx_q;
      addr_d  = addr_q;
      sdo_d   = sdo_q;
      oe_d    = oe_q;
      wr_en   = 1'b0;
      wr_idx  = mem_idx(sync2_q.bank_select, addr_q);
      if (!en) begin
         // held in reset while disabled
         state_d = SSR_ST_ADDR;
         cnt_d   = SSR_CNT_RST;
         rx_d    = SSR_BYTE_RST;
         tx_d    = SSR_BYTE_RST;
         addr_d  = SSR_ADDR_RST;
         sdo_d   = SSR_SDO_IDLE;
         oe_d    = 1'b0;
      end else begin
         if (sck_rise) begin
            cnt_d = cnt_q + 3'h1;
            rx_d  = cap_byte;
         end
         if (byte_done) begin
            case (state_q)
               SSR_ST_ADDR: begin
                  // decode address/control byte
                  if (cap_byte[SSR_DIR_BIT] == SSR_DIR_READ) begin
                     state_d = SSR_ST_READ;
                     tx_d    = mem[mem_idx(sync2_q.bank_select,
                                           cap_byte[SSR_ADDR_W-1:0])];
                     addr_d  = addr_next(cap_byte[SSR_ADDR_W-1:0]);
                     oe_d    = 1'b1;
                  end else begin
                     state_d = SSR_ST_WRITE;
                     addr_d  = cap_byte[SSR_ADDR_W-1:0];
                  end
               end
               SSR_ST_WRITE: begin
                  // store the completed data byte, then advance
                  wr_en  = 1'b1;
                  addr_d = addr_next(addr_q);
               end
               SSR_ST_READ: begin
                  // fetch the following byte before its first falling edge
                  tx_d   = mem[mem_idx(sync2_q.bank_select, addr_q)];
                  addr_d = addr_next(addr_q);
               end
               default: begin
                  state_d = SSR_ST_ADDR;
               end
            endcase
         end
         if (sck_fall && state_q == SSR_ST_READ) begin
            // drive next bit on the trailing edge, stable by the next rise
            sdo_d = tx_q[SSR_BYTE_W-1];
            tx_d  = {tx_q[SSR_BYTE_W-2:0], 1'b0};
         end
      end
   end

   // register the serial engine
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_q <= SSR_ST_ADDR;
         cnt_q   <= SSR_CNT_RST;
         rx_q    <= SSR_BYTE_RST;
         tx_q    <= SSR_BYTE_RST;
         addr_q  <= SSR_ADDR_RST;
         sdo_q   <= SSR_SDO_IDLE;
         oe_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         rx_q    <= rx_d;
         tx_q    <= tx_d;
         addr_q  <= addr_d;
         sdo_q   <= sdo_d;
         oe_q    <= oe_d;
      end
   end

   // memory write port, contents are not reset
   always_ff @(posedge i_clk_sys) begin
      if (wr_en) begin
         mem[wr_idx] <= cap_byte;
      end
   end

   // outputs straight from flip-flops
   assign o_sdo    = sdo_q;
   assign o_sdo_oe = oe_q;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // a completed address byte with the read direction
   sequence s_addr_read;
      byte_done && state_q == SSR_ST_ADDR && cap_byte[SSR_DIR_BIT] == 1'b0;
   endsequence

   // a completed address byte with the write direction
   sequence s_addr_write;
      byte_done && state_q == SSR_ST_ADDR && cap_byte[SSR_DIR_BIT] == 1'b1;
   endsequence

   // a completed data byte in a write cycle
   sequence s_data_write;
      byte_done && state_q == SSR_ST_WRITE;
   endsequence

   // the interface comes back after a disabled cycle
   sequence s_reenable;
      !en ##1 en;
   endsequence

   property p_busy_needs_en;
      (state_q != SSR_ST_ADDR || oe_q) |-> $past(en);
   endproperty
   a_busy_needs_en: assert property (p_busy_needs_en)
      else $error("interface active without enable");

   property p_dis_reset;
      !en |=> (state_q == SSR_ST_ADDR && cnt_q == 3'h0 && !o_sdo_oe && o_sdo);
   endproperty
   a_dis_reset: assert property (p_dis_reset)
      else $error("interface not held in reset while disabled");

   property p_dis_ignores_sck;
      (!en && sync2_q.sck != sck_last_q) |=> cnt_q == 3'h0;
   endproperty
   a_dis_ignores_sck: assert property (p_dis_ignores_sck)
      else $error("serial clock counted while disabled");

   property p_read_start;
      s_addr_read |=> (state_q == SSR_ST_READ && o_sdo_oe
                       && addr_q == $past(cap_byte[6:0]) + 7'h01);
   endproperty
   a_read_start: assert property (p_read_start)
      else $error("read address byte decoded wrongly");

   property p_write_start;
      s_addr_write |=> (state_q == SSR_ST_WRITE && !o_sdo_oe
                        && addr_q == $past(cap_byte[6:0]));
   endproperty
   a_write_start: assert property (p_write_start)
      else $error("write address byte decoded wrongly");

   property p_write_store;
      s_data_write |=> (mem[$past(wr_idx)] == $past(cap_byte)
                        && addr_q == $past(addr_q) + 7'h01);
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("write byte not stored or address not advanced");

   property p_sdo_on_fall;
      (sck_fall && state_q == SSR_ST_READ) |=> o_sdo == $past(tx_q[7]);
   endproperty
   a_sdo_on_fall: assert property (p_sdo_on_fall)
      else $error("serial output not updated on trailing edge");

   property p_sdo_steady;
      (state_q == SSR_ST_READ && en && !sck_fall) ##1 en |-> $stable(o_sdo);
   endproperty
   a_sdo_steady: assert property (p_sdo_steady)
      else $error("serial output changed away from trailing edge");

   property p_new_address;
      s_reenable |-> (state_q == SSR_ST_ADDR && cnt_q == 3'h0);
   endproperty
   a_new_address: assert property (p_new_address)
      else $error("re-enabled interface does not expect an address byte");

   property p_count_byte;
      (en && state_q == SSR_ST_ADDR && sck_rise) |=> cnt_q == $past(cnt_q) + 3'h1;
   endproperty
   a_count_byte: assert property (p_count_byte)
      else $error("bit counter did not advance on rising edge");

   // a completed data byte in a read cycle
   sequence s_read_end;
      byte_done && state_q == SSR_ST_READ;
   endsequence

   // a completed data byte while the word address sits at the end of a half
   sequence s_last_word;
      byte_done && state_q != SSR_ST_ADDR && addr_q == 7'h7f;
   endsequence

   // output enable only while a read cycle runs
   property p_oe_in_read;
      o_sdo_oe |-> state_q == SSR_ST_READ;
   endproperty
   a_oe_in_read: assert property (p_oe_in_read)
      else $error("output enable raised outside a read cycle");

   // serial output rests at its idle level outside read cycles
   property p_sdo_idle;
      state_q != SSR_ST_READ |-> o_sdo == SSR_SDO_IDLE;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle)
      else $error("serial output moved outside a read cycle");

   // each read byte fetches the following word and stays in the read cycle
   property p_read_advance;
      s_read_end |=> (state_q == SSR_ST_READ && addr_q == $past(addr_q) + 7'h01);
   endproperty
   a_read_advance: assert property (p_read_advance)
      else $error("read burst did not advance the word address");

   // the last word of a half is followed by word zero of the same half
   property p_addr_wrap;
      s_last_word |=> addr_q == 7'h00;
   endproperty
   a_addr_wrap: assert property (p_addr_wrap)
      else $error("word address did not wrap inside its half");

   // every gated rising edge shifts the synchronised data bit in at the bottom
   property p_rx_capture;
      sck_rise |=> rx_q == {$past(rx_q[SSR_BYTE_W-2:0]), $past(sync2_q.sdi)};
   endproperty
   a_rx_capture: assert property (p_rx_capture)
      else $error("input bit not captured on serial clock rise");

   // while enabled, the bit counter only moves on a rising serial clock edge
   property p_cnt_hold;
      (en && !sck_rise) |=> cnt_q == $past(cnt_q);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("bit counter moved without a rising edge");

   // the read shifter moves one place towards the msb on each trailing edge
   property p_tx_shift;
      (sck_fall && state_q == SSR_ST_READ) |=> tx_q == {$past(tx_q[SSR_BYTE_W-2:0]), 1'b0};
   endproperty
   a_tx_shift: assert property (p_tx_shift)
      else $error("read shifter did not move msb first");

   // a write cycle never turns the serial output on
   property p_write_no_oe;
      state_q == SSR_ST_WRITE |-> !o_sdo_oe;
   endproperty
   a_write_no_oe: assert property (p_write_no_oe)
      else $error("output enabled during a write cycle");

   // storage is written only by a completed data byte of a write cycle
   property p_store_only_write;
      wr_en |-> (byte_done && state_q == SSR_ST_WRITE);
   endproperty
   a_store_only_write: assert property (p_store_only_write)
      else $error("storage written outside a completed write byte");

   // the phase register holds only the three defined phases
   property p_state_legal;
      state_q inside {SSR_ST_ADDR, SSR_ST_READ, SSR_ST_WRITE};
   endproperty
   a_state_legal: assert property (p_state_legal)
      else $error("interface phase left the defined set");

endmodule

// [testbench/ssr_master_model.sv]
// ssr_master_model: serial master that drives the link pins of the sram slave
// assumes i_clk is the 100 ns system clock; serial clock period is 8 of its cycles
module ssr_master_model (
   // system
   input  wire logic          i_clk,
   // link
   input  wire logic          i_sdo,
   output ssr_pkg::ssr_pins_t o_pins,
   // received byte
   output logic               o_rx_vld,
   output logic [7:0]         o_rx
);
   timeunit 1ns;
   timeprecision 100ps;
   import ssr_pkg::*;

   // pins idle: disabled, clock high
   initial begin
      o_pins   = SSR_PINS_RST;
      o_rx_vld = 1'b0;
      o_rx     = 8'h00;
   end

   // wait n clocks, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #10;
   endtask

   // change enable pins and bank only between frames; enable is held for a whole frame
   task automatic sel(input logic ce, input logic ss_n, input logic bank);
      tick(4);
      o_pins.ce          = ce;
      o_pins.ss_n        = ss_n;
      o_pins.bank_select = bank;
      o_pins.sdi         = ~o_pins.sdi; // idle data line keeps moving
   endtask

   // shift n bits msb first: change on the falling edge, sample on the rising
   task automatic xfer(input logic [7:0] tx, input int n);
      logic [7:0] rx;
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         tick(4);
         o_pins.sck = 1'b0;
         o_pins.sdi = tx[7-i];
         tick(4);
         o_pins.sck = 1'b1;
         rx = {rx[6:0], i_sdo};
      end
      o_rx       = rx;
      o_rx_vld   = 1'b1;
      tick(1);
      o_rx_vld   = 1'b0;
      o_pins.sdi = ~o_pins.sdi;
   endtask
endmodule

// [testbench/tb_serial_sram_slave_interface.sv]
// tb_serial_sram_slave_interface: self-checking bench for the serial sram slave
// assumes the master model drives all link pins; 10 MHz system clock
module tb_serial_sram_slave_interface;
   timeunit 1ns;
   timeprecision 100ps;
   import ssr_pkg::*;

   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       chk = 1'b0;
   ssr_pins_t  pins;
   logic       sdo;
   logic       sdo_oe;
   logic       rx_vld;
   logic [7:0] rx;
   logic [7:0] mem_exp [256];
   logic [7:0] exp_q [$];
   int         bad_count = 0;
   int         checks = 0;
   int         seed = 81486;
   logic [6:0] ra;
   logic       rb;

   always #50 clk = ~clk;

   ssr_serial_sram #(.P_TWO_BANKS(1'b1)) DUT (.i_clk_sys(clk), .i_rst(rst), .i_pins(pins),
                                              .o_sdo(sdo), .o_sdo_oe(sdo_oe));
   ssr_master_model m (.i_clk(clk), .i_sdo(sdo), .o_pins(pins), .o_rx_vld(rx_vld), .o_rx(rx));

   // ----------------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      if (exp_q.size() != 0) bad_count++;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // oldest note against each read byte the master received
   always @(posedge clk) begin
      if (rx_vld === 1'b1 && chk === 1'b1) begin
         check(rx, exp_q.pop_front());
      end
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      test_done();
   end

   // ----------------------------------------------------------------------
   // transfers
   // ----------------------------------------------------------------------
   // write burst of n random bytes, one address byte only
   task automatic wr(input logic bank, input logic [6:0] a, input int n);
      logic [7:0] d;
      m.sel(1'b1, 1'b0, bank);
      m.xfer({1'b1, a}, 8);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         m.xfer(d, 8);
         mem_exp[{bank, a}] = d;
         a = a + 7'h01;
      end
      m.sel(1'b0, 1'b1, bank);
   endtask

   // read burst of n bytes, notes expected data, checks output enable
   task automatic rd(input logic bank, input logic [6:0] a, input int n);
      m.sel(1'b1, 1'b0, bank);
      m.xfer({SSR_DIR_READ, a}, 8);
      m.tick(4);
      check({7'h00, sdo_oe}, 8'h01);
      chk = 1'b1;
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(mem_exp[{bank, a}]);
         m.xfer(8'h00, 8);
         a = a + 7'h01;
      end
      chk = 1'b0;
      m.sel(1'b0, 1'b1, bank);
      m.tick(6);
      check({7'h00, sdo_oe}, 8'h00);
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      #10;
      rst = 1'b0;
      m.tick(4);
      wr(1'b0, 7'h7e, 4);
      wr(1'b1, 7'h7e, 4);
      rd(1'b0, 7'h7e, 4);
      rd(1'b1, 7'h7f, 3);
      ra = 7'($random(seed));
      rb = 1'($random(seed));
      wr(rb, ra, 3);
      rd(rb, ra, 3);
      $display("burst and wrap test done");
      // partial byte then deselect must not store
      m.sel(1'b1, 1'b0, 1'b0);
      m.xfer({1'b1, 7'h7e}, 8);
      m.xfer(~mem_exp[8'h7e], 5);
      m.sel(1'b0, 1'b1, 1'b0);
      rd(1'b0, 7'h7e, 1);
      $display("partial byte test done");
      // serial clock while only one enable condition holds
      for (int j = 0; j < 2; j++) begin
         m.sel(j[0], j[0], 1'b0);
         m.xfer({1'b1, 7'h7e}, 8);
         m.xfer(~mem_exp[8'h7e], 8);
      end
      m.sel(1'b0, 1'b1, 1'b0);
      rd(1'b0, 7'h7e, 1);
      $display("gating test done");
      test_done();
   end
endmodule
